// ===== design/tcmc_channel_ctrl.sv
// timer channel mode control: channel control registers, interlocks,
// input capture path for four channels, channel 0 compare shadow and output
// assumes enable and protection levels come from logic on i_clk
// and that counter, update and trigger pulses arrive on i_clk as well

`timescale 1ns/1ps

module tcmc_channel_ctrl (
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_n,
	input  wire tcmc_pkg::tcmc_bus_req_t i_bus,
	input  wire tcmc_pkg::tcmc_cnt_t     i_cnt,
	input  wire logic [3:0]              i_ch_enable,
	input  wire logic [1:0]              i_protection_level,
	input  wire logic [3:0]              i_ch_pin,
	input  wire logic                    i_internal_trigger_signal,
	output logic [31:0]                  o_rdata,
	output logic [3:0]                   o_capture,
	output logic [3:0]                   o_filtered,
	output logic                         o_ch0_prepared_output,
	output logic [15:0]                  o_ch0_active_compare
);
	import tcmc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// output mode test shared by the interlocks, edge detect and compare path
	function automatic logic is_output(input logic [1:0] ms);
		return ms == MS_OUTPUT;
	endfunction : is_output

	// last phase of a divide-by-2^n period of the dead-time tick
	function automatic logic div_phase(input logic [4:0] cnt, input int n);
		logic [4:0] mask;
		mask = 5'((1 << n) - 1);
		return (cnt & mask) == mask;
	endfunction : div_phase

	// merge a written channel byte with the stored one under the interlocks
	function automatic logic [7:0] merge_byte(
		input logic [7:0] old_b,
		input logic [7:0] new_b,
		input logic       enabled,
		input logic [1:0] protection_level
	);
		logic [7:0] r;
		r = new_b;
		if (enabled) begin
			r[MS_LSB +: 2] = old_b[MS_LSB +: 2];
		end
		// lock judged on the mode already stored, not the one being written
		if (protection_level == PROTECTION_LEVEL_LOCKED && is_output(old_b[MS_LSB +: 2])) begin
			r[COMCTL_LSB +: 3] = old_b[COMCTL_LSB +: 3];
			r[SHADOW_BIT]      = old_b[SHADOW_BIT];
		end
		return r;
	endfunction : merge_byte

	// edge count at which the prescaler fires; the capture then clears it
	function automatic logic [2:0] psc_limit(input logic [1:0] psc);
		logic [2:0] l;
		case (psc)
			2'h0:    l = 3'h0;
			2'h1:    l = 3'h1;
			2'h2:    l = 3'h3;
			default: l = 3'h7;
		endcase
		return l;
	endfunction : psc_limit

	// prepared pwm level for a counter value against the compare value
	function automatic logic pwm_level(
		input logic [2:0]  mode,
		input logic        down,
		input logic [15:0] cnt,
		input logic [15:0] cv
	);
		logic lvl;
		lvl = down ? (cnt <= cv) : (cnt < cv);
		return (mode == CMP_PWM1) ? ~lvl : lvl;
	endfunction : pwm_level

	////////////////////////////////////////////////////////////////////////
	// register file

	logic [15:0] ctrl01;
	logic [15:0] ctrl23;
	logic [15:0] cmp_preload;

	wire hit01 = i_bus.addr == ADDR_CTRL_CH0_CH1;
	wire hit23 = i_bus.addr == ADDR_CTRL_CH2_CH3;
	wire hitcv = i_bus.addr == ADDR_CH0_CMP_VAL;

	wire wr01 = i_bus.wr && hit01;
	wire wr23 = i_bus.wr && hit23;
	wire wrcv = i_bus.wr && hitcv;

	// upper bits are not stored, so reserved bits always read zero
	wire [15:0] next_ctrl01 = {
		merge_byte(ctrl01[15:8], i_bus.wdata[15:8], i_ch_enable[1], i_protection_level),
		merge_byte(ctrl01[7:0],  i_bus.wdata[7:0],  i_ch_enable[0], i_protection_level)
	};
	wire [15:0] next_ctrl23 = {
		merge_byte(ctrl23[15:8], i_bus.wdata[15:8], i_ch_enable[3], i_protection_level),
		merge_byte(ctrl23[7:0],  i_bus.wdata[7:0],  i_ch_enable[2], i_protection_level)
	};
	wire [15:0] next_preload = wrcv ? i_bus.wdata[15:0] : cmp_preload;

	// unmapped offsets read as zero
	logic [31:0] rd_sel;
	always_comb begin
		rd_sel = 32'h0000_0000;
		if (hit01) begin
			rd_sel = {16'h0000, ctrl01};
		end else if (hit23) begin
			rd_sel = {16'h0000, ctrl23};
		end else if (hitcv) begin
			rd_sel = {16'h0000, cmp_preload};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl01      <= CTRL_RESET;
			ctrl23      <= CTRL_RESET;
			cmp_preload <= CMP_VAL_RESET;
		end else begin
			if (wr01) begin
				ctrl01 <= next_ctrl01;
			end
			if (wr23) begin
				ctrl23 <= next_ctrl23;
			end
			cmp_preload <= next_preload;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			// cleared between reads so a stale word never lingers on the bus
			o_rdata <= i_bus.rd ? rd_sel : 32'h0000_0000;
		end
	end

	// per-channel view of the shared storage
	logic [7:0] chb [4];
	assign chb[0] = ctrl01[7:0];
	assign chb[1] = ctrl01[15:8];
	assign chb[2] = ctrl23[7:0];
	assign chb[3] = ctrl23[15:8];

	////////////////////////////////////////////////////////////////////////
	// sample rate enables

	// dead-time tick from the kernel clock; a ratio of one ticks every cycle
	logic [3:0] dts_cnt;
	logic [4:0] div_cnt;
	wire        dts_tick = dts_cnt == (DTS_DIV - 4'h1);
	wire  [5:0] ticks;

	// free divider: sample phases are not tied to input edges
	assign ticks[0] = 1'b1;
	assign ticks[1] = dts_tick && div_phase(div_cnt, 1);
	assign ticks[2] = dts_tick && div_phase(div_cnt, 2);
	assign ticks[3] = dts_tick && div_phase(div_cnt, 3);
	assign ticks[4] = dts_tick && div_phase(div_cnt, 4);
	assign ticks[5] = dts_tick && div_phase(div_cnt, 5);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dts_cnt <= 4'h0;
			div_cnt <= 5'h00;
		end else begin
			dts_cnt <= dts_tick ? 4'h0 : dts_cnt + 4'h1;
			if (dts_tick) begin
				div_cnt <= div_cnt + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input path: synchroniser, filter, source select, prescaler

	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [3:0] filt;
	logic [3:0] src;
	logic [3:0] src_d;
	logic [2:0] psc_cnt [4];
	logic [3:0] rise;
	logic [3:0] fire;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= i_ch_pin;
			pin_sync <= pin_meta;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			wire [1:0] ms       = chb[g][MS_LSB +: 2];
			// input view of the upper four bits, shared with the compare fields
			wire [3:0] flt_code = chb[g][FLT_LSB +: 4];
			wire [1:0] psc_code = chb[g][PSC_LSB +: 2];

			tcmc_input_filter u_filter (
				.i_clk   (i_clk),
				.i_rst_n (i_rst_n),
				.i_level (pin_sync[g]),
				.i_code  (flt_code),
				.i_ticks (ticks),
				.o_level (filt[g])
			);

			// neighbour pairs are 0/1 and 2/3
			assign src[g] =
				(ms == MS_OWN)   ? filt[g] :
				(ms == MS_NEIGH) ? filt[g ^ 1] :
				(ms == MS_ITS)   ? i_internal_trigger_signal : 1'b0;
			// rising edges only; polarity selection sits ahead of this block
			assign rise[g] = src[g] && !src_d[g] && !is_output(ms);
			assign fire[g] = rise[g] && psc_cnt[g] == psc_limit(psc_code);

			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					psc_cnt[g] <= 3'h0;
				end else if (!i_ch_enable[g]) begin
					psc_cnt[g] <= 3'h0;
				end else if (fire[g]) begin
					psc_cnt[g] <= 3'h0;
				end else if (rise[g]) begin
					psc_cnt[g] <= psc_cnt[g] + 3'h1;
				end
			end
		end
	endgenerate

	// src_d resets to the idle source level, so no false edge follows reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			src_d      <= 4'h0;
			o_capture  <= 4'h0;
			o_filtered <= 4'h0;
		end else begin
			src_d      <= src;
			o_capture  <= fire & i_ch_enable;
			o_filtered <= filt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel 0 compare value and prepared output

	wire        shadow_en = chb[0][SHADOW_BIT];
	wire        fast_en   = chb[0][FAST_BIT];
	wire  [2:0] comctl    = chb[0][COMCTL_LSB +: 3];
	wire        out_mode  = is_output(chb[0][MS_LSB +: 2]);
	wire        is_pwm    = comctl == CMP_PWM0 || comctl == CMP_PWM1;

	// remembered so a timing-to-pwm switch and a result change show up
	// no single pulse input here: software keeps the shadow on for pwm
	logic [2:0] prev_comctl;
	logic       prev_res;

	// without shadow the compare value follows a write at once
	wire [15:0] next_active =
		!shadow_en   ? next_preload :
		i_cnt.update ? cmp_preload : o_ch0_active_compare;

	wire match  = i_cnt.value == o_ch0_active_compare;
	wire res    = pwm_level(comctl, i_cnt.down, i_cnt.value, o_ch0_active_compare);
	wire at_cmp = pwm_level(comctl, i_cnt.down, o_ch0_active_compare, o_ch0_active_compare);
	// at_cmp is the level the comparison gives at the compare value itself

	// set, clear and toggle act on equality; force modes ignore the counter
	logic next_prep;
	always_comb begin
		next_prep = o_ch0_prepared_output;
		if (out_mode) begin
			case (comctl)
				CMP_SET:    next_prep = match ? 1'b1 : o_ch0_prepared_output;
				CMP_CLEAR:  next_prep = match ? 1'b0 : o_ch0_prepared_output;
				CMP_TOGGLE: next_prep = match ? ~o_ch0_prepared_output : o_ch0_prepared_output;
				CMP_FLOW:   next_prep = 1'b0;
				CMP_FHIGH:  next_prep = 1'b1;
				CMP_PWM0, CMP_PWM1: begin
					if (fast_en && i_cnt.trig_edge) begin
						next_prep = at_cmp;
					end else if (prev_comctl == CMP_TIMING || res != prev_res) begin
						next_prep = res;
					end
				end
				default:    next_prep = o_ch0_prepared_output;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ch0_active_compare  <= CMP_VAL_RESET;
			o_ch0_prepared_output <= 1'b0;
			prev_comctl           <= CMP_TIMING;
			prev_res              <= 1'b0;
		end else begin
			o_ch0_active_compare  <= next_active;
			o_ch0_prepared_output <= next_prep;
			prev_comctl           <= comctl;
			prev_res              <= is_pwm ? res : prev_res;
		end
	end

endmodule : tcmc_channel_ctrl

// ===== design/tcmc_input_filter.sv
// timer channel mode control: digital input filter for one channel
// assumes i_level is already synchronised; i_ticks[0] is the kernel rate,
// i_ticks[5:1] the dead-time clock divided by 2,4,8,16,32

`timescale 1ns/1ps

module tcmc_input_filter (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_level,
	input  wire logic [3:0] i_code,
	input  wire logic [5:0] i_ticks,
	output logic            o_level
);
	import tcmc_pkg::*;

	// sample rate index and number of equal samples for each code
	function automatic logic [2:0] rate_sel(input logic [3:0] code);
		logic [2:0] r;
		r = 3'h0;
		if (code <= 4'h3) begin
			r = 3'h0;
		end else if (code <= 4'h5) begin
			r = 3'h1;
		end else if (code <= 4'h7) begin
			r = 3'h2;
		end else if (code <= 4'h9) begin
			r = 3'h3;
		end else if (code <= 4'hC) begin
			r = 3'h4;
		end else begin
			r = 3'h5;
		end
		return r;
	endfunction : rate_sel

	function automatic logic [3:0] need(input logic [3:0] code);
		logic [3:0] n;
		case (code)
			4'h1:    n = 4'h2;
			4'h2:    n = 4'h4;
			4'h3:    n = 4'h8;
			4'h4, 4'h6, 4'h8, 4'hB, 4'hE: n = 4'h6;
			4'hA, 4'hD: n = 4'h5;
			default: n = 4'h8;
		endcase
		return n;
	endfunction : need

	logic [3:0] run;
	wire        sample_en = i_ticks[rate_sel(i_code)];
	wire  [3:0] run_inc   = run + 4'h1;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= 1'b0;
			run     <= 4'h0;
		end else if (i_code == 4'h0) begin
			o_level <= i_level;
			run     <= 4'h0;
		end else if (sample_en) begin
			if (i_level == o_level) begin
				run <= 4'h0;
			end else if (run_inc >= need(i_code)) begin
				o_level <= i_level;
				run     <= 4'h0;
			end else begin
				run <= run_inc;
			end
		end
	end

endmodule : tcmc_input_filter

// ===== inc/tcmc_pkg.sv
// timer channel mode control: shared constants, field layout and carriers
// assumes one kernel clock; counter, enable and protection state arrive from outside

package tcmc_pkg;

	// register byte addresses
	localparam logic [7:0]  ADDR_CTRL_CH0_CH1 = 8'h18;
	localparam logic [7:0]  ADDR_CTRL_CH2_CH3 = 8'h1C;
	localparam logic [7:0]  ADDR_CH0_CMP_VAL  = 8'h34;

	// values after reset
	localparam logic [15:0] CTRL_RESET        = 16'h0000;
	localparam logic [15:0] CMP_VAL_RESET     = 16'h0000;

	// field positions inside one channel byte
	localparam int          MS_LSB            = 0;
	localparam int          FAST_BIT          = 2;
	localparam int          SHADOW_BIT        = 3;
	localparam int          COMCTL_LSB        = 4;
	localparam int          PSC_LSB           = 2;
	localparam int          FLT_LSB           = 4;

	localparam logic [1:0]  PROTECTION_LEVEL_LOCKED       = 2'h3;

	// dead-time clock ratio to the kernel clock (kernel cycles per tick)
	localparam logic [3:0]  DTS_DIV           = 4'h1;

	typedef enum logic [1:0] {
		MS_OUTPUT = 2'b00,
		MS_OWN    = 2'b01,
		MS_NEIGH  = 2'b10,
		MS_ITS    = 2'b11
	} tcmc_ms_t;

	typedef enum logic [2:0] {
		CMP_TIMING = 3'b000,
		CMP_SET    = 3'b001,
		CMP_CLEAR  = 3'b010,
		CMP_TOGGLE = 3'b011,
		CMP_FLOW   = 3'b100,
		CMP_FHIGH  = 3'b101,
		CMP_PWM0   = 3'b110,
		CMP_PWM1   = 3'b111
	} tcmc_comctl_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tcmc_bus_req_t;

	typedef struct packed {
		logic [15:0] value;
		logic        down;
		logic        update;
		logic        trig_edge;
	} tcmc_cnt_t;

endpackage : tcmc_pkg

// ===== tb/tcmc_channel_ctrl_tb.sv
// directed bench for the channel control block
// assumes the block alone on one 25 MHz clock; bench drives every port
`timescale 1ns/1ps
module tcmc_channel_ctrl_tb;
	import tcmc_pkg::*;
	logic          i_clk      = 1'b0;
	logic          i_rst_n    = 1'b0;
	tcmc_bus_req_t bus        = '0;
	tcmc_cnt_t     cnt        = '0;
	logic [3:0]    en         = 4'h0;
	logic [1:0]    protection_level       = 2'h0;
	logic [3:0]    pin        = 4'h0;
	logic          internal_trigger_signal        = 1'b0;
	logic [31:0]   rdata;
	logic [3:0]    capture;
	logic [3:0]    filtered;
	logic          prep;
	logic [15:0]   act;
	logic          hi;
	logic [3:0]    fc [3]     = '{4'h1, 4'h3, 4'h4};
	int            gl [3]     = '{1, 6, 8};
	int            mismatches = 0;
	int            tests_run  = 0;
	int            cap        = 0;
	int            c0;
	int            k;
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) if (capture[0] === 1'b1) cap <= cap + 1;
	tcmc_channel_ctrl tcmc_channel_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus),
		.i_cnt(cnt), .i_ch_enable(en), .i_protection_level(protection_level), .i_ch_pin(pin),
		.i_internal_trigger_signal(internal_trigger_signal), .o_rdata(rdata), .o_capture(capture),
		.o_filtered(filtered), .o_ch0_prepared_output(prep), .o_ch0_active_compare(act));
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask : w
	task automatic r(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
		@(posedge i_clk);
	endtask : r
	// counter moves, then the prepared level is judged once it has settled
	task automatic pwm(input logic [15:0] v, input logic d, input logic exp);
		cnt.value <= v;
		cnt.down  <= d;
		cyc(3);
		#1 chk(32'(prep), 32'(exp));
		@(posedge i_clk);
	endtask : pwm
	// source 4 is the internal trigger
	task automatic edges(input int ch, input int n, input int h);
		repeat (n) begin
			if (ch < 4) pin[ch] <= 1'b1; else internal_trigger_signal <= 1'b1;
			cyc(h);
			if (ch < 4) pin[ch] <= 1'b0; else internal_trigger_signal <= 1'b0;
			cyc(h);
		end
	endtask : edges
	// capture count after a reprogram with the channel held off meanwhile
	task automatic src(input logic [7:0] b, input int ch, input int n, input int exp);
		en <= 4'h0;
		w(ADDR_CTRL_CH0_CH1, {24'h0, b});
		en <= 4'h1;
		c0 = cap;
		edges(ch, n, 3);
		cyc(8);
		chk(32'(cap - c0), 32'(exp));
	endtask : src
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		mismatches++;
		stop_test();
	end
	initial begin
		cyc(16);
		i_rst_n <= 1'b1;
		cyc(1);
		r(ADDR_CTRL_CH0_CH1, 32'h0);
		r(ADDR_CTRL_CH2_CH3, 32'h0);
		r(ADDR_CH0_CMP_VAL, 32'h0);
		r(8'h20, 32'h0);
		w(ADDR_CTRL_CH2_CH3, 32'h0000A5C3);
		r(ADDR_CTRL_CH2_CH3, 32'h0000A5C3);
		en <= 4'h4;
		w(ADDR_CTRL_CH2_CH3, 32'h00005A3C);
		r(ADDR_CTRL_CH2_CH3, 32'h00005A3F);
		en <= 4'h0;
		w(ADDR_CH0_CMP_VAL, 32'h00000080);
		#1 chk(32'(act), 32'h0080);
		w(ADDR_CTRL_CH0_CH1, 32'h50);
		pwm(16'h0010, 1'b0, 1'b1);
		w(ADDR_CTRL_CH0_CH1, 32'h00);
		pwm(16'h0090, 1'b0, 1'b1);
		// pwm only with the compare shadow on
		w(ADDR_CTRL_CH0_CH1, 32'h68);
		pwm(16'h0090, 1'b0, 1'b0);
		pwm(16'h0010, 1'b0, 1'b1);
		pwm(16'h0080, 1'b1, 1'b1);
		pwm(16'h0081, 1'b1, 1'b0);
		w(ADDR_CTRL_CH0_CH1, 32'h78);
		pwm(16'h0081, 1'b1, 1'b1);
		pwm(16'h0010, 1'b0, 1'b0);
		w(ADDR_CTRL_CH0_CH1, 32'h6C);
		pwm(16'h0010, 1'b0, 1'b1);
		cnt.trig_edge <= 1'b1;
		cyc(1);
		cnt.trig_edge <= 1'b0;
		// same comparison result afterwards, so the forced level must stay
		pwm(16'h0010, 1'b0, 1'b0);
		protection_level <= PROTECTION_LEVEL_LOCKED;
		w(ADDR_CTRL_CH0_CH1, 32'h00000090);
		r(ADDR_CTRL_CH0_CH1, 32'h000000E8);
		protection_level <= 2'h0;
		w(ADDR_CTRL_CH0_CH1, 32'h08);
		w(ADDR_CH0_CMP_VAL, 32'h5678);
		r(ADDR_CH0_CMP_VAL, 32'h00005678);
		chk(32'(act), 32'h0080);
		cnt.update <= 1'b1;
		cyc(1);
		cnt.update <= 1'b0;
		#1 chk(32'(act), 32'h5678);
		for (k = 0; k < 3; k++) begin
			w(ADDR_CTRL_CH0_CH1, {24'h0, fc[k], 4'h1});
			hi = 1'b0;
			pin[0] <= 1'b1;
			cyc(gl[k]);
			pin[0] <= 1'b0;
			repeat (30) begin
				@(posedge i_clk);
				hi = hi | filtered[0];
			end
			chk(32'(hi), 32'h0);
			pin[0] <= 1'b1;
			cyc(40);
			chk(32'(filtered[0]), 32'h1);
			pin[0] <= 1'b0;
			cyc(40);
		end
		for (k = 0; k < 4; k++) src(8'(k * 4 + 1), 0, 8, 8 >> k);
		edges(0, 3, 3);
		src(8'h0D, 0, 5, 0);
		src(8'h02, 1, 2, 2);
		// the bench stands in for the trigger selection ahead of mode 11
		src(8'h03, 4, 2, 2);
		stop_test();
	end
endmodule : tcmc_channel_ctrl_tb

// ===== tb/tcmc_monitor.sv
// port checks for the channel control block
// assumes one kernel clock and the block's async active-low reset
`timescale 1ns/1ps
module tcmc_monitor
	import tcmc_pkg::*;
(
	input wire logic          i_clk,
	input wire logic          i_rst_n,
	input wire tcmc_bus_req_t i_bus,
	input wire tcmc_cnt_t     i_cnt,
	input wire logic [3:0]    i_ch_enable,
	input wire logic [1:0]    i_protection_level,
	input wire logic [3:0]    i_ch_pin,
	input wire logic          i_internal_trigger_signal,
	input wire logic [31:0]   o_rdata,
	input wire logic [3:0]    o_capture,
	input wire logic [3:0]    o_filtered,
	input wire logic          o_ch0_prepared_output,
	input wire logic [15:0]   o_ch0_active_compare
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_cmp_write;
		i_bus.wr && i_bus.addr == ADDR_CH0_CMP_VAL && !i_cnt.update;
	endsequence
	sequence s_off_two;
		!i_ch_enable[0] ##1 !i_ch_enable[0];
	endsequence
	a_rdata_idle_zero: assert property (!i_bus.rd |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_upper_bits_zero: assert property (o_rdata[31:16] == 16'h0000)
		else $error("reserved read bits not zero");
	a_cmp_write_load: assert property (s_cmp_write |=>
		o_ch0_active_compare == $past(i_bus.wdata[15:0]) || $stable(o_ch0_active_compare))
		else $error("compare write gave a foreign value");
	a_cmp_no_cause: assert property (!(i_bus.wr && i_bus.addr == ADDR_CH0_CMP_VAL)
		&& !i_cnt.update |=> $stable(o_ch0_active_compare))
		else $error("active compare moved without cause");
	a_capture_off_quiet: assert property (s_off_two |=> !o_capture[0])
		else $error("capture while channel disabled");
	a_capture_one_pulse: assert property (o_capture[0] |=> !o_capture[0])
		else $error("capture pulse longer than one cycle");
	a_filter_ch0_cause: assert property ($changed(o_filtered[0])
		|-> $past(i_ch_pin[0], 3) == o_filtered[0])
		else $error("channel 0 filter moved against its input");
	a_filter_ch1_cause: assert property ($changed(o_filtered[1])
		|-> $past(i_ch_pin[1], 3) == o_filtered[1])
		else $error("channel 1 filter moved against its input");
endmodule : tcmc_monitor
bind tcmc_channel_ctrl tcmc_monitor tcmc_monitor_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_bus(i_bus), .i_cnt(i_cnt), .i_ch_enable(i_ch_enable), .i_ch_pin(i_ch_pin),
	.i_protection_level(i_protection_level), .o_rdata(o_rdata), .o_capture(o_capture),
	.i_internal_trigger_signal(i_internal_trigger_signal), .o_filtered(o_filtered),
	.o_ch0_prepared_output(o_ch0_prepared_output),
	.o_ch0_active_compare(o_ch0_active_compare));
